/* hw/rar_pkg.sv */
// Package: register map, field layout, reset values and state codes
package rar_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] RAR_LIMIT_OFS = 8'h5c;
  localparam logic [7:0] RAR_AVGSHIFT_OFS = 8'h5e;
  localparam logic [7:0] RAR_NOISE_OFS = 8'h5f;
  localparam logic [7:0] RAR_AVG_OFS = 8'h60;
  localparam logic [7:0] RAR_PEAK_OFS = 8'h61;
  localparam logic [7:0] RAR_LOW_OFS = 8'h62;
  localparam logic [7:0] RAR_VBUS_OFS = 8'h63;
  // Field positions
  localparam int RAR_GTH_POS = 3;
  localparam int RAR_RETRY_POS = 0;
  localparam int RAR_AVGN_POS = 5;
  localparam int RAR_SHIFT_POS = 0;
  localparam int RAR_NOISE_POS = 0;
  localparam int RAR_DISCH_POS = 1;
  // Writable bit masks
  localparam logic [7:0] RAR_LIMIT_MASK = 8'h7f;
  localparam logic [7:0] RAR_NOISE_MASK = 8'h3f;
  localparam logic [7:0] RAR_VBUS_MASK = 8'h02;
  // Reset values
  localparam logic [7:0] RAR_LIMIT_RST = 8'h21;
  localparam logic [7:0] RAR_AVGSHIFT_RST = 8'h23;
  localparam logic [7:0] RAR_NOISE_RST = 8'h00;
  localparam logic [7:0] RAR_RESULT_RST = 8'h00;
  localparam logic [7:0] RAR_VBUS_RST = 8'h00;
  // Forced result codes
  localparam logic [7:0] RAR_CODE_LOW = 8'h00;
  localparam logic [7:0] RAR_CODE_FULL = 8'hff;
  // Measurement sequencer states
  typedef enum logic [1:0] {
    RAR_M_IDLE = 2'b00,
    RAR_M_SAMPLE = 2'b01,
    RAR_M_EVAL = 2'b10
  } rar_meas_state_type;
  // Serial slave states
  typedef enum logic [2:0] {
    RAR_S_IDLE = 3'b000,
    RAR_S_ADDR = 3'b001,
    RAR_S_AACK = 3'b010,
    RAR_S_WRITE = 3'b011,
    RAR_S_WACK = 3'b100,
    RAR_S_READ = 3'b101,
    RAR_S_RACK = 3'b110
  } rar_ser_state_type;
endpackage

/* hw/rar_regbus_if.sv */
// Interface: register access between serial slave and register file
`timescale 1ns/1ps
`default_nettype none
interface rar_regbus_if;
  logic [7:0] addr;  // Register pointer
  logic [7:0] wdata; // Write data
  logic wr;          // One-cycle write strobe
  logic [7:0] rdata; // Read data at pointer
  modport ctrl (output addr, output wdata, output wr, input rdata);
  modport regs (input addr, input wdata, input wr, output rdata);
endinterface
`default_nettype wire

/* hw/rar_i2c_slave.sv */
// Serial two-wire register slave with auto-incrementing pointer
`timescale 1ns/1ps
`default_nettype none
module rar_i2c_slave import rar_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary neutral address
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_r,
  rar_regbus_if.ctrl bus
);
  logic scl_s1_r, scl_s2_r, scl_d_r; // Clock line synchroniser and delay
  logic sda_s1_r, sda_s2_r, sda_d_r; // Data line synchroniser and delay
  rar_ser_state_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;        // Bit counter within byte
  logic [7:0] sh_r, sh_nxt;          // Shift register
  logic [7:0] ptr_r, ptr_nxt;        // Register pointer
  logic [7:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt;
  logic rw_r, rw_nxt;                // Transfer direction, high for read
  logic first_r, first_nxt;          // Next written byte is the pointer
  logic inc_r, inc_nxt;              // Pointer step pending after data write
  logic oe_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Two flops before any logic, third stage for edge detection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'b111;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'b111;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
    end
  end

  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_c = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_c = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // Next-state logic of the byte engine
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0;
    rw_nxt = rw_r;
    first_nxt = first_r;
    inc_nxt = inc_r;
    oe_nxt = sda_oe_r;
    if (stop_c) begin
      // A stop always returns to idle, so a host can recover the bus with it
      st_nxt = RAR_S_IDLE;
      oe_nxt = 1'b0;
    end else if (start_c) begin
      st_nxt = RAR_S_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      unique case (st_r)
        RAR_S_ADDR, RAR_S_WRITE: begin
          sh_nxt = {sh_r[6:0], sda_s2_r};
          cnt_nxt = cnt_r + 4'h1;
        end
        RAR_S_READ: cnt_nxt = cnt_r + 4'h1;
        RAR_S_RACK: if (sda_s2_r) st_nxt = RAR_S_IDLE; // Host refused more data
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_r)
        RAR_S_ADDR: if (cnt_r == 4'h8) begin
          if (sh_r[7:1] == DEV_ADDR) begin
            st_nxt = RAR_S_AACK;
            oe_nxt = 1'b1;
            rw_nxt = sh_r[0];
            first_nxt = ~sh_r[0];
          end else begin
            st_nxt = RAR_S_IDLE;
          end
        end
        RAR_S_AACK: begin
          cnt_nxt = 4'h0;
          if (rw_r) begin
            st_nxt = RAR_S_READ;
            sh_nxt = bus.rdata;
            oe_nxt = ~bus.rdata[7];
          end else begin
            st_nxt = RAR_S_WRITE;
            oe_nxt = 1'b0;
          end
        end
        RAR_S_WRITE: if (cnt_r == 4'h8) begin
          st_nxt = RAR_S_WACK;
          oe_nxt = 1'b1;
          if (first_r) begin
            ptr_nxt = sh_r;
            first_nxt = 1'b0;
          end else begin
            wr_nxt = 1'b1;
            wdata_nxt = sh_r;
            inc_nxt = 1'b1;
          end
        end
        RAR_S_WACK: begin
          st_nxt = RAR_S_WRITE;
          cnt_nxt = 4'h0;
          oe_nxt = 1'b0;
          if (inc_r) ptr_nxt = ptr_r + 8'h01;
          inc_nxt = 1'b0;
        end
        RAR_S_READ: if (cnt_r == 4'h8) begin
          st_nxt = RAR_S_RACK;
          oe_nxt = 1'b0;
          ptr_nxt = ptr_r + 8'h01;
        end else begin
          sh_nxt = {sh_r[6:0], 1'b0};
          oe_nxt = ~sh_r[6];
        end
        RAR_S_RACK: begin
          st_nxt = RAR_S_READ;
          cnt_nxt = 4'h0;
          sh_nxt = bus.rdata;
          oe_nxt = ~bus.rdata[7];
        end
        default: ;
      endcase
    end
  end

  // Registers of the byte engine; power-on reset leaves it idle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= RAR_S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      inc_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      inc_r <= inc_nxt;
      sda_oe_r <= oe_nxt;
    end
  end

  assign bus.addr = ptr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
endmodule
`default_nettype wire

/* hw/rar_top.sv */
// Resistive ADC averaging, result registers and discharge control
//
// Function
// - Average two to the N samples
// - Subtract sideband shift on sideband-only measurements
// - Noise margin separates open from retry or abort on a saturated pass
// - Average register loaded, forced on outcomes
// - Peak register loaded, forced on outcomes
// - Lowest register loaded, forced on outcomes
// - Logic held reset until supply good
// - Ground when average at or below threshold and no sample saturated
// - Retry saturated measurement unless it reads open, then report abort
`timescale 1ns/1ps
`default_nettype none
module rar_top import rar_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_r,
  output logic sda_oe_r,
  input wire logic meas_start,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  input wire logic sbu_only,
  input wire logic pullup_min,
  output logic meas_done_r,
  output logic result_ground_r,
  output logic result_abort_r,
  output logic result_open_r,
  output logic discharge_en_r
);
  rar_regbus_if bus ();

  // Register file state
  logic [7:0] limit_r, limit_nxt;       // Ground threshold and retry count
  logic [7:0] avgshift_r, avgshift_nxt; // Averaging count and shift factor
  logic [7:0] noise_r, noise_nxt;       // Noise clamp margin
  logic discharge_nxt;
  // Measurement state
  rar_meas_state_type ms_r, ms_nxt;
  logic [14:0] acc_r, acc_nxt;          // Holds 128 full-scale samples
  logic [7:0] cnt_r, cnt_nxt;           // Samples taken this pass
  logic [7:0] peak_r, peak_nxt;
  logic [7:0] low_r, low_nxt;
  logic [2:0] tries_r, tries_nxt;       // Retries used so far
  logic [7:0] avg_res_r, avg_res_nxt;   // Final average reading
  logic [7:0] peak_res_r, peak_res_nxt; // Final peak reading
  logic [7:0] low_res_r, low_res_nxt;   // Final lowest reading
  logic done_nxt, gnd_nxt, abort_nxt, open_nxt;
  // Decoded fields and evaluation terms
  logic [2:0] avg_n, retry_cnt;
  logic [3:0] gth;
  logic [4:0] shift_f;
  logic [5:0] margin;
  logic [7:0] target, sample, avg_calc, gnd_level, open_level;
  logic [14:0] acc_shifted;
  logic saturated, near_full, retry_cond;

  rar_i2c_slave u_ser (
    .mclk(mclk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_r(sda_oe_r),
    .bus(bus.ctrl)
  );

  // Saturating subtraction keeps tiny readings from wrapping to full scale
  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [4:0] b);
    logic [7:0] bw;
    bw = {3'b000, b};
    return (a > bw) ? a - bw : 8'h00;
  endfunction

  assign avg_n = avgshift_r[RAR_AVGN_POS +: 3];
  assign shift_f = avgshift_r[RAR_SHIFT_POS +: 5];
  assign gth = limit_r[RAR_GTH_POS +: 4];
  assign retry_cnt = limit_r[RAR_RETRY_POS +: 3];
  assign margin = noise_r[RAR_NOISE_POS +: 6];

  // Sample count and averaging by shift
  assign target = 8'h01 << avg_n;
  assign acc_shifted = acc_r >> avg_n;
  assign avg_calc = acc_shifted[7:0];
  // Shift factor applies only when sideband lines alone are pulled up
  assign sample = sbu_only ? sat_sub(adc_data, shift_f) : adc_data;
  // Open needs the average within the noise margin of full scale
  assign open_level = RAR_CODE_FULL - {2'b00, margin};
  assign near_full = avg_calc >= open_level;
  assign saturated = peak_r == RAR_CODE_FULL;
  assign retry_cond = saturated & (~pullup_min | ~near_full);
  assign gnd_level = {gth, 4'h0};

  // Register reads; unmapped and reserved bits read zero
  always_comb begin
    unique case (bus.addr)
      RAR_LIMIT_OFS: bus.rdata = limit_r;
      RAR_AVGSHIFT_OFS: bus.rdata = avgshift_r;
      RAR_NOISE_OFS: bus.rdata = noise_r;
      RAR_AVG_OFS: bus.rdata = avg_res_r;
      RAR_PEAK_OFS: bus.rdata = peak_res_r;
      RAR_LOW_OFS: bus.rdata = low_res_r;
      RAR_VBUS_OFS: bus.rdata = {6'h00, discharge_en_r, 1'b0};
      default: bus.rdata = 8'h00;
    endcase
  end

  // Register writes; result registers ignore writes
  always_comb begin
    limit_nxt = limit_r;
    avgshift_nxt = avgshift_r;
    noise_nxt = noise_r;
    discharge_nxt = discharge_en_r;
    if (bus.wr) begin
      unique case (bus.addr)
        RAR_LIMIT_OFS: limit_nxt = bus.wdata & RAR_LIMIT_MASK;
        RAR_AVGSHIFT_OFS: avgshift_nxt = bus.wdata;
        RAR_NOISE_OFS: noise_nxt = bus.wdata & RAR_NOISE_MASK;
        RAR_VBUS_OFS: discharge_nxt = bus.wdata[RAR_DISCH_POS];
        default: ;
      endcase
    end
  end

  // Measurement sequencer next state
  always_comb begin
    ms_nxt = ms_r;
    acc_nxt = acc_r;
    cnt_nxt = cnt_r;
    peak_nxt = peak_r;
    low_nxt = low_r;
    tries_nxt = tries_r;
    avg_res_nxt = avg_res_r;
    peak_res_nxt = peak_res_r;
    low_res_nxt = low_res_r;
    done_nxt = 1'b0;
    gnd_nxt = result_ground_r;
    abort_nxt = result_abort_r;
    open_nxt = result_open_r;
    unique case (ms_r)
      RAR_M_IDLE: if (meas_start) begin
        ms_nxt = RAR_M_SAMPLE;
        acc_nxt = 15'h0000;
        cnt_nxt = 8'h00;
        tries_nxt = 3'h0;
      end
      RAR_M_SAMPLE: if (adc_valid) begin
        acc_nxt = acc_r + {7'h00, sample};
        cnt_nxt = cnt_r + 8'h01;
        peak_nxt = (cnt_r == 8'h00 || sample > peak_r) ? sample : peak_r;
        low_nxt = (cnt_r == 8'h00 || sample < low_r) ? sample : low_r;
        if (cnt_r + 8'h01 == target) ms_nxt = RAR_M_EVAL;
      end
      RAR_M_EVAL: begin
        if (retry_cond && tries_r < retry_cnt) begin
          // Saturated pass is thrown away and taken again
          ms_nxt = RAR_M_SAMPLE;
          tries_nxt = tries_r + 3'h1;
          acc_nxt = 15'h0000;
          cnt_nxt = 8'h00;
        end else begin
          ms_nxt = RAR_M_IDLE;
          done_nxt = 1'b1;
          abort_nxt = retry_cond;
          open_nxt = ~retry_cond & saturated;
          gnd_nxt = ~saturated & (avg_calc <= gnd_level);
          if (retry_cond || (!saturated && avg_calc <= gnd_level)) begin
            avg_res_nxt = RAR_CODE_LOW;
            peak_res_nxt = RAR_CODE_LOW;
            low_res_nxt = RAR_CODE_LOW;
          end else if (saturated) begin
            avg_res_nxt = RAR_CODE_FULL;
            peak_res_nxt = RAR_CODE_FULL;
            low_res_nxt = RAR_CODE_FULL;
          end else begin
            avg_res_nxt = avg_calc;
            peak_res_nxt = peak_r;
            low_res_nxt = low_r;
          end
        end
      end
      default: ms_nxt = RAR_M_IDLE; // Unused code recovers to idle
    endcase
  end

  // All state registers; reset is the power-on reset, held until supply good
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      limit_r <= RAR_LIMIT_RST;
      avgshift_r <= RAR_AVGSHIFT_RST;
      noise_r <= RAR_NOISE_RST;
      discharge_en_r <= RAR_VBUS_RST[RAR_DISCH_POS];
      ms_r <= RAR_M_IDLE;
      acc_r <= 15'h0000;
      cnt_r <= 8'h00;
      peak_r <= 8'h00;
      low_r <= 8'h00;
      tries_r <= 3'h0;
      avg_res_r <= RAR_RESULT_RST;
      peak_res_r <= RAR_RESULT_RST;
      low_res_r <= RAR_RESULT_RST;
      meas_done_r <= 1'b0;
      result_ground_r <= 1'b0;
      result_abort_r <= 1'b0;
      result_open_r <= 1'b0;
      sda_out_r <= 1'b0;
    end else begin
      limit_r <= limit_nxt;
      avgshift_r <= avgshift_nxt;
      noise_r <= noise_nxt;
      discharge_en_r <= discharge_nxt;
      ms_r <= ms_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      peak_r <= peak_nxt;
      low_r <= low_nxt;
      tries_r <= tries_nxt;
      avg_res_r <= avg_res_nxt;
      peak_res_r <= peak_res_nxt;
      low_res_r <= low_res_nxt;
      meas_done_r <= done_nxt;
      result_ground_r <= gnd_nxt;
      result_abort_r <= abort_nxt;
      result_open_r <= open_nxt;
      sda_out_r <= 1'b0; // Open drain: only ever pulls low
    end
  end

  // Checks on the sequencer and the discharge enable
  sequence eval_finish;
    ##1 meas_done_r;
  endsequence
  sequence eval_again;
    ##1 (ms_r == RAR_M_SAMPLE && !meas_done_r && cnt_r == 8'h00);
  endsequence

  sample_count_a: assert property (@(posedge mclk) disable iff (reset)
    ms_r == RAR_M_SAMPLE && adc_valid && cnt_r + 8'h01 == target |=> ms_r == RAR_M_EVAL)
    else $error("sample count did not end the pass");
  shift_applied_a: assert property (@(posedge mclk) disable iff (reset)
    ms_r == RAR_M_SAMPLE && adc_valid && sbu_only && adc_data <= {3'b000, shift_f}
    |=> low_r == 8'h00)
    else $error("sideband shift not applied");
  noise_open_a: assert property (@(posedge mclk) disable iff (reset)
    ms_r == RAR_M_EVAL && saturated && pullup_min && near_full
    |-> eval_finish ##0 result_open_r && avg_res_r == RAR_CODE_FULL)
    else $error("open outcome not reported");
  avg_forced_a: assert property (@(posedge mclk) disable iff (reset)
    meas_done_r && (result_abort_r || result_ground_r) |-> avg_res_r == RAR_CODE_LOW)
    else $error("average not forced low");
  peak_forced_a: assert property (@(posedge mclk) disable iff (reset)
    meas_done_r && result_open_r |-> peak_res_r == RAR_CODE_FULL && !result_ground_r)
    else $error("peak not forced full");
  low_forced_a: assert property (@(posedge mclk) disable iff (reset)
    meas_done_r && (result_abort_r || result_ground_r) |-> low_res_r == RAR_CODE_LOW)
    else $error("lowest not forced low");
  ground_report_a: assert property (@(posedge mclk) disable iff (reset)
    ms_r == RAR_M_EVAL && !saturated && avg_calc <= gnd_level
    |-> eval_finish ##0 result_ground_r)
    else $error("ground outcome missed");
  retry_taken_a: assert property (@(posedge mclk) disable iff (reset)
    ms_r == RAR_M_EVAL && retry_cond && tries_r < retry_cnt |-> eval_again)
    else $error("saturated pass not retried");
  abort_report_a: assert property (@(posedge mclk) disable iff (reset)
    ms_r == RAR_M_EVAL && retry_cond && tries_r >= retry_cnt
    |-> eval_finish ##0 result_abort_r)
    else $error("abort outcome missed");
  discharge_bit_a: assert property (@(posedge mclk) disable iff (reset)
    bus.wr && bus.addr == RAR_VBUS_OFS |=> discharge_en_r == $past(bus.wdata[RAR_DISCH_POS]))
    else $error("discharge enable did not follow write");
endmodule
`default_nettype wire

/* verification/rar_host_model.sv */
// Two-wire bus host model that reaches the device registers
`timescale 1ns/1ps
`default_nettype none
module rar_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary, same as design default
  parameter int HALF = 6 // Mclk per clock phase, above the slave's minimum of 2
) (
  input wire logic mclk,
  input wire logic sda_wire,
  output logic scl_out,
  output logic sda_low
);
  // Bus idles released, pull-ups give high
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end
  // Falling-edge waits keep changes away from the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start_c();
    sda_low = 1'b0;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
    tick(1);
  endtask
  // Stop: data rises while clock high; also clears a suspended bus
  task automatic stop_c();
    sda_low = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
  // One bit; data moves a cycle after clock falls so the slave never sees a false start
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    r = sda_wire;
    scl_out = 1'b0;
    tick(1);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                        output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r[i]);
    end
    bit_x(ack_in, ack_out);
  endtask
  // Pointer then data, ok when every byte was acknowledged
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, r, k0);
    byte_x(a, 1'b1, r, k1);
    byte_x(d, 1'b1, r, k2);
    stop_c();
    ok = !(k0 || k1 || k2);
  endtask
  // Pointer, repeated start, one byte back with a closing nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, r, k0);
    byte_x(a, 1'b1, r, k1);
    start_c();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, r, k2);
    byte_x(8'hff, 1'b1, d, k3);
    stop_c();
    ok = !(k0 || k1 || k2);
  endtask
endmodule
`default_nettype wire

/* verification/rar_top_bench.sv */
// Self-checking bench for the resistive ADC result and control block
`timescale 1ns/1ps
`default_nettype none
module rar_top_bench import rar_pkg::*;;
  localparam logic [7:0] SHIFT = 8'h03; // Shift factor kept at its default
  logic mclk, reset, scl_in, sda_in, sda_low, sda_out_r, sda_oe_r, ok;
  logic meas_start, adc_valid, sbu_only, pullup_min, meas_done_r, discharge_en_r;
  logic result_ground_r, result_abort_r, result_open_r;
  logic [7:0] adc_data, rd, lvl, pk, lo; // Pk and lo track the current batch
  int n_errors, checks_done, seed, sum, nl;
  logic [7:0] ra[8] = '{RAR_LIMIT_OFS, RAR_AVGSHIFT_OFS, RAR_NOISE_OFS, RAR_AVG_OFS,
    RAR_PEAK_OFS, RAR_LOW_OFS, RAR_VBUS_OFS, 8'h5d};
  logic [7:0] rv[8] = '{8'h21, 8'h23, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] dv[3] = '{8'hff, 8'h00, 8'h02};
  // Open-drain data line with pull-up
  assign sda_in = !(sda_low || sda_oe_r);
  // 10 MHz clock
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  rar_top u_dut (.mclk(mclk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r), .meas_start(meas_start),
    .adc_valid(adc_valid), .adc_data(adc_data), .sbu_only(sbu_only),
    .pullup_min(pullup_min), .meas_done_r(meas_done_r), .result_ground_r(result_ground_r),
    .result_abort_r(result_abort_r), .result_open_r(result_open_r),
    .discharge_en_r(discharge_en_r));
  rar_host_model u_host (.mclk(mclk), .sda_wire(sda_in), .scl_out(scl_in), .sda_low(sda_low));
  // Counts and ends the run
  task automatic give_verdict();
    $display("Counts: %0d mismatches in %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Case-equal compare, an unknown matches only an unknown in the same bit
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d, ok);
    chk({7'h0, ok}, 8'h01, "write ack");
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    u_host.read_reg(a, rd, ok);
    chk({7'h0, ok}, 8'h01, "read ack");
    chk(rd, exp, "register read");
  endtask
  // Sideband sample after shift, floored at zero
  function automatic logic [7:0] eff(input logic [7:0] d, input logic sbu);
    if (!sbu)
      return d;
    return (d > SHIFT) ? d - SHIFT : 8'h00;
  endfunction
  task automatic start_m();
    @(negedge mclk);
    meas_start = 1'b1;
    @(negedge mclk);
    meas_start = 1'b0;
  endtask
  // One batch: mode 0 plain, 1 first sample saturated, 2 all saturated
  task automatic batch(input int mode);
    logic [7:0] d, e;
    sum = 0;
    pk = 8'h00;
    lo = 8'hff;
    for (int i = 0; i < (1 << nl); i++) begin
      // Second sample, except in mode 2, is a sideband corner that the shift floors at zero
      d = (mode == 2 || (mode == 1 && i == 0)) ? 8'hff :
        (i == 1) ? 8'h02 : 8'(8 + $unsigned($random(seed)) % 193);
      sbu_only = (d == 8'hff) ? 1'b0 : (d == 8'h02) | 1'($random(seed));
      e = eff(d, sbu_only);
      sum += e;
      pk = (e > pk) ? e : pk;
      lo = (e < lo) ? e : lo;
      adc_valid = 1'b1;
      adc_data = d;
      @(negedge mclk);
    end
    adc_valid = 1'b0;
  endtask
  // Bounded wait for the completion pulse, which must last one cycle
  task automatic wait_done(input logic want);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      seen = (meas_done_r === 1'b1);
      if (!seen) @(negedge mclk);
    end
    chk({7'h0, seen}, {7'h0, want}, "completion pulse");
    if (want && !seen) give_verdict();
    if (seen) begin
      @(negedge mclk);
      chk({7'h0, meas_done_r}, 8'h00, "pulse width");
    end
  endtask
  // Flags are ground, abort, open
  task automatic chk_out(input logic [7:0] a, input logic [7:0] p, input logic [7:0] l,
                         input logic [2:0] f);
    chk({5'h0, result_ground_r, result_abort_r, result_open_r}, {5'h0, f}, "outcome");
    rdc(RAR_AVG_OFS, a);
    rdc(RAR_PEAK_OFS, p);
    rdc(RAR_LOW_OFS, l);
  endtask
  task automatic chk_norm();
    logic [7:0] avg;
    avg = 8'(sum >> nl);
    if (avg <= lvl) chk_out(8'h00, 8'h00, 8'h00, 3'b100);
    else chk_out(avg, pk, lo, 3'b000);
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    {meas_start, adc_valid, sbu_only, pullup_min} = 4'h0;
    adc_data = 8'h00;
    {seed, n_errors, checks_done, nl} = {32'd4, 32'd0, 32'd0, 32'd1};
    lvl = 8'h00;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    u_host.stop_c();
    foreach (ra[i]) rdc(ra[i], rv[i]);
    foreach (dv[i]) begin
      wr(RAR_VBUS_OFS, dv[i]);
      chk({7'h0, discharge_en_r}, {7'h0, dv[i][1]}, "discharge path");
      rdc(RAR_VBUS_OFS, dv[i] & 8'h02);
    end
    wr(RAR_AVG_OFS, 8'h5a);
    rdc(RAR_AVG_OFS, 8'h00);
    wr(RAR_LIMIT_OFS, 8'h00);
    // Every averaging count, random data and sideband flags
    for (nl = 0; nl < 8; nl++) begin
      wr(RAR_AVGSHIFT_OFS, {nl[2:0], SHIFT[4:0]});
      pullup_min = 1'($random(seed));
      start_m();
      batch(0);
      wait_done(1'b1);
      chk_norm();
    end
    nl = 1;
    wr(RAR_AVGSHIFT_OFS, 8'h23);
    wr(RAR_LIMIT_OFS, 8'h78);
    lvl = 8'hf0;
    start_m();
    batch(0);
    wait_done(1'b1);
    chk_norm();
    lvl = 8'h00;
    wr(RAR_LIMIT_OFS, 8'h00);
    pullup_min = 1'b0;
    start_m();
    batch(1);
    wait_done(1'b1);
    chk_out(RAR_CODE_LOW, RAR_CODE_LOW, RAR_CODE_LOW, 3'b010);
    pullup_min = 1'b1;
    start_m();
    batch(2);
    wait_done(1'b1);
    chk_out(RAR_CODE_FULL, RAR_CODE_FULL, RAR_CODE_FULL, 3'b001);
    // One retry: clean second batch passes, saturated second batch aborts
    wr(RAR_LIMIT_OFS, 8'h01);
    for (int k = 0; k < 2; k++) begin
      pullup_min = k[0];
      start_m();
      batch(1);
      wait_done(1'b0);
      batch(k);
      wait_done(1'b1);
      if (k == 0) chk_norm();
      else chk_out(RAR_CODE_LOW, RAR_CODE_LOW, RAR_CODE_LOW, 3'b010);
    end
    // Reset in mid-run returns outputs and registers to their start state
    reset = 1'b1;
    repeat (3) @(negedge mclk);
    chk({2'h0, sda_out_r, result_open_r, discharge_en_r, meas_done_r, result_abort_r,
      result_ground_r}, 8'h00, "reset");
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    u_host.stop_c();
    rdc(RAR_VBUS_OFS, 8'h00);
    rdc(RAR_LIMIT_OFS, 8'h21);
    give_verdict();
  end
endmodule
`default_nettype wire
